// >>> gpio_port.sv
// How it works
// - a pin whose direction bit is 0 is an input with its driver off, which is the reset state.
// - a pin whose direction bit is 1 has its driver on.
// - an output pin is driven to its bit of the output latch.
// - the latch bit of an input pin has no effect on the pin.
// - reading the input register gives the latch value for every output pin.
// - bits 15 to 12 of all three registers read as zero.
// - the direction register is read-write at 0x33 and resets to zero.
// - the output latch register is read-write at 0x34 and resets to zero.
// - the input register at 0x35 is read-only and follows the live pins.
module gpio_port (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire gpio_port_pkg::reg_req_t req_i,
   output gpio_port_pkg::reg_rsp_t rsp_o,
   input wire gpio_port_pkg::pin_bank_t pin_i,
   output gpio_port_pkg::pin_bank_t pin_o,
   output gpio_port_pkg::pin_bank_t pin_oe_n_o
);
   import gpio_port_pkg::*;

   pin_bank_t dir_q;
   pin_bank_t latch_q;
   pin_bank_t sampled;
   pin_bank_t level;
   reg_rsp_t rsp_q;
   logic wr_dir;
   logic wr_latch;
   logic [REG_W-1:0] rdata_d;

   // write decode; a write to the input register or an unknown offset is dropped
   assign wr_dir = req_i.wr && (req_i.addr == PIN_DIRECTION_ADDR);
   assign wr_latch = req_i.wr && (req_i.addr == PIN_OUTPUT_LATCH_ADDR);

   // direction register; reserved bits are never stored
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         dir_q <= PIN_DIRECTION_RESET;
      end else if (wr_dir) begin
         dir_q <= req_i.wdata[PIN_COUNT-1:0];
      end
   end

   // output latch; kept even for inputs so a later direction flip drives it
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         latch_q <= PIN_OUTPUT_LATCH_RESET;
      end else if (wr_latch) begin
         latch_q <= req_i.wdata[PIN_COUNT-1:0];
      end
   end

   // external levels come from another timing world, so two flops first
   pin_sync #(
      .WIDTH(PIN_COUNT)
   ) u_sync (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .async_i(pin_i),
      .sync_o(sampled)
   );

   // pad control and readback selection
   pin_driver #(
      .WIDTH(PIN_COUNT)
   ) u_driver (
      .dir_i(dir_q),
      .latch_i(latch_q),
      .sampled_i(sampled),
      .pin_o(pin_o),
      .pin_oe_n_o(pin_oe_n_o),
      .level_o(level)
   );

   // read mux; reserved bits and unknown offsets give zero
   always_comb begin
      rdata_d = '0;
      unique case (req_i.addr)
         PIN_DIRECTION_ADDR: rdata_d = {RESERVED_READ, dir_q};
         PIN_OUTPUT_LATCH_ADDR: rdata_d = {RESERVED_READ, latch_q};
         PIN_INPUT_LEVEL_ADDR: rdata_d = {RESERVED_READ, level};
         default: rdata_d = '0;
      endcase
   end

   // read answer is registered: data from a flop, valid one cycle after rd
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         rsp_q <= '0;
      end else begin
         rsp_q.rvalid <= req_i.rd;
         rsp_q.rdata <= req_i.rd ? rdata_d : '0;
      end
   end

   assign rsp_o = rsp_q;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   // after reset every driver is off
   reset_hiz_a: assert property ($past(rst_i) |-> pin_oe_n_o == '1)
      else $error("pins not high-impedance after reset");

   // a direction write turns drivers on or off one cycle later
   drive_enable_a: assert property (wr_dir |=> pin_oe_n_o == ~$past(req_i.wdata[PIN_COUNT-1:0]))
      else $error("driver enables do not follow direction write");

   // a latch write shows on output pins one cycle later
   drive_value_a: assert property (wr_latch |=>
      (pin_o & ~pin_oe_n_o) == ($past(req_i.wdata[PIN_COUNT-1:0]) & ~pin_oe_n_o))
      else $error("output pins do not carry latch value");

   // a latch write never turns on the driver of an input pin
   latch_ignored_a: assert property (wr_latch && !wr_dir |=> $stable(pin_oe_n_o))
      else $error("latch write changed pin direction");

   // output pins read back their latch bit
   readback_out_a: assert property (req_i.rd && req_i.addr == PIN_INPUT_LEVEL_ADDR |=>
      rsp_o.rvalid && ((rsp_o.rdata[PIN_COUNT-1:0] & $past(dir_q)) ==
      ($past(latch_q) & $past(dir_q))))
      else $error("output pin readback differs from latch");

   // reserved bits of every answer are zero
   reserved_zero_a: assert property (rsp_o.rvalid |-> rsp_o.rdata[REG_W-1:PIN_COUNT] == RESERVED_READ)
      else $error("reserved read bits not zero");

   // direction written then read back returns the written bits
   dir_readback_a: assert property (wr_dir ##1 (req_i.rd && req_i.addr == PIN_DIRECTION_ADDR &&
      !req_i.wr) |=> rsp_o.rdata[PIN_COUNT-1:0] == $past(req_i.wdata[PIN_COUNT-1:0], 2))
      else $error("direction register readback wrong");

   // latch written then read back returns the written bits
   latch_readback_a: assert property (wr_latch ##1 (req_i.rd &&
      req_i.addr == PIN_OUTPUT_LATCH_ADDR && !req_i.wr) |=>
      rsp_o.rdata[PIN_COUNT-1:0] == $past(req_i.wdata[PIN_COUNT-1:0], 2))
      else $error("latch register readback wrong");

   // a write to the input register touches nothing
   input_ro_a: assert property (req_i.wr && req_i.addr == PIN_INPUT_LEVEL_ADDR |=>
      $stable(dir_q) && $stable(latch_q))
      else $error("write to input register changed state");

   // an input pin held steady reads back its level after the synchroniser
   input_level_a: assert property (req_i.rd && req_i.addr == PIN_INPUT_LEVEL_ADDR &&
      $stable(pin_i) && $past($stable(pin_i)) |=>
      (rsp_o.rdata[PIN_COUNT-1:0] & ~$past(dir_q)) == ($past(pin_i) & ~$past(dir_q)))
      else $error("input pin level not returned");

   // group a sits in the low nibble of the pin bus
   group_map_a: assert property (wr_dir |=>
      pin_oe_n_o.grp_a == ~$past(req_i.wdata[GROUP_W-1:0]))
      else $error("group a bit mapping wrong");
endmodule : gpio_port

// >>> gpio_port_pkg.sv
package gpio_port_pkg;
   // sizes of the port and of its register words
   localparam int PIN_COUNT = 12;
   localparam int GROUP_W = 4;
   localparam int REG_W = 16;
   localparam int ADDR_W = 7;
   localparam int SYNC_STAGES = 2;

   // register offsets
   localparam logic [ADDR_W-1:0] PIN_DIRECTION_ADDR = 7'h33;
   localparam logic [ADDR_W-1:0] PIN_OUTPUT_LATCH_ADDR = 7'h34;
   localparam logic [ADDR_W-1:0] PIN_INPUT_LEVEL_ADDR = 7'h35;

   // reset values; every pin leaves reset as a high-impedance input
   localparam logic [PIN_COUNT-1:0] PIN_DIRECTION_RESET = 12'h000;
   localparam logic [PIN_COUNT-1:0] PIN_OUTPUT_LATCH_RESET = 12'h000;

   // value of the reserved upper bits on every read
   localparam logic [REG_W-PIN_COUNT-1:0] RESERVED_READ = 4'h0;

   // one bit per pin, group c in the high nibble, group a in the low one
   typedef struct packed {
      logic [GROUP_W-1:0] grp_c;
      logic [GROUP_W-1:0] grp_b;
      logic [GROUP_W-1:0] grp_a;
   } pin_bank_t;

   // register access request, taken on one clock edge
   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [REG_W-1:0] wdata;
   } reg_req_t;

   // read answer, one cycle after the request
   typedef struct packed {
      logic rvalid;
      logic [REG_W-1:0] rdata;
   } reg_rsp_t;
endpackage : gpio_port_pkg

// >>> pin_driver.sv
module pin_driver #(
   parameter int WIDTH = 12
) (
   input wire logic [WIDTH-1:0] dir_i,
   input wire logic [WIDTH-1:0] latch_i,
   input wire logic [WIDTH-1:0] sampled_i,
   output logic [WIDTH-1:0] pin_o,
   output logic [WIDTH-1:0] pin_oe_n_o,
   output logic [WIDTH-1:0] level_o
);
   // per pin: driver enable, driven value and the level seen by software
   for (genvar i = 0; i < WIDTH; i++) begin : g_pin
      assign pin_oe_n_o[i] = ~dir_i[i];
      assign pin_o[i] = latch_i[i];
      // an output pin reads back its own latch, an input its synced level
      assign level_o[i] = dir_i[i] ? latch_i[i] : sampled_i[i];
   end
endmodule : pin_driver

// >>> pin_far_end.sv
module pin_far_end
   import gpio_port_pkg::*;
(
   input wire gpio_port_pkg::pin_bank_t ext_i,
   input wire gpio_port_pkg::pin_bank_t pin_o_i,
   input wire gpio_port_pkg::pin_bank_t oe_n_i,
   output gpio_port_pkg::pin_bank_t pad_o
);
   // an enabled device driver wins the pad, otherwise the outside source sets it
   assign pad_o = (oe_n_i & ext_i) | (~oe_n_i & pin_o_i);
endmodule : pin_far_end

// >>> pin_sync.sv
module pin_sync #(
   parameter int WIDTH = 12
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] stage1_q;
   logic [WIDTH-1:0] stage2_q;

   // two flops against metastability; only stage2 looks at stage1
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         stage1_q <= '0;
         stage2_q <= '0;
      end else begin
         stage1_q <= async_i;
         stage2_q <= stage1_q;
      end
   end

   assign sync_o = stage2_q;
endmodule : pin_sync

// >>> twelve_pin_gpio_port_tb.sv
module twelve_pin_gpio_port_tb
   import gpio_port_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   reg_req_t req = '0;
   reg_rsp_t rsp;
   pin_bank_t pin_i, pin_o, oe_n;
   pin_bank_t ext = 12'h000;
   int n_mismatch = 0;
   int num_checks = 0;
   int cycles = 0;

   // free-running 100 MHz clock
   always #5 ref_clk_i = ~ref_clk_i;

   gpio_port gpio_port_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(req), .rsp_o(rsp),
      .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n_o(oe_n));
   pin_far_end pin_far_end_i (.ext_i(ext), .pin_o_i(pin_o), .oe_n_i(oe_n), .pad_o(pin_i));

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_of_test

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp

   // one-cycle write pulse, launched and released on falling edges
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      @(negedge ref_clk_i);
      req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge ref_clk_i);
      req = '0;
   endtask : wr

   // the answer stands one cycle only, so it is judged in that cycle
   task automatic rd(input logic [6:0] a, input logic [15:0] exp);
      @(negedge ref_clk_i);
      req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(negedge ref_clk_i);
      req = '0;
      cmp({15'h0000, rsp.rvalid}, 16'h0001);
      cmp(rsp.rdata, exp);
   endtask : rd

   task automatic t_reset();
      rd(7'h33, 16'h0000);
      rd(7'h34, 16'h0000);
      cmp({4'h0, oe_n}, 16'h0fff);
      cmp({4'h0, pin_o}, 16'h0000);
      $display("test reset done");
   endtask : t_reset

   task automatic t_inputs();
      wr(7'h34, 16'hffa5);
      rd(7'h34, 16'h0fa5);
      cmp({4'h0, oe_n}, 16'h0fff);
      ext = 12'h35c;
      repeat (3) @(negedge ref_clk_i);
      rd(7'h35, 16'h035c);
      $display("test inputs done");
   endtask : t_inputs

   task automatic t_outputs();
      wr(7'h33, 16'hf0f0);
      rd(7'h33, 16'h00f0);
      cmp({4'h0, oe_n}, 16'h0f0f);
      cmp({4'h0, pin_i}, 16'h03ac);
      repeat (3) @(negedge ref_clk_i);
      rd(7'h35, 16'h03ac);
      $display("test outputs done");
   endtask : t_outputs

   task automatic t_refuse();
      wr(7'h35, 16'hffff);
      rd(7'h34, 16'h0fa5);
      rd(7'h35, 16'h03ac);
      rd(7'h40, 16'h0000);
      wr(7'h33, 16'h0000);
      cmp({4'h0, oe_n}, 16'h0fff);
      $display("test refuse done");
   endtask : t_refuse

   // a hung run is cut short well past the expected 42 or so cycles
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles >= 2000) begin
         n_mismatch++;
         end_of_test();
      end
   end

   // reset for ten cycles, then the scenarios in turn
   initial begin
      repeat (10) @(negedge ref_clk_i);
      rst_i = 1'b0;
      t_reset();
      t_inputs();
      t_outputs();
      t_refuse();
      end_of_test();
   end
endmodule : twelve_pin_gpio_port_tb
